/* sfb_pkg.sv */
// Purpose: constants, register map and attribute table for the bank-1 register block
// Assumes: one byte register per aligned 32-bit word, byte address = index * 4
// Notes: shaded slots carry zero read and write masks
// Overview of operation
// - shaded or unimplemented slots and bits read zero and ignore writes.
// - the program counter upper bits are never read or written directly; a low-byte load copies the latch into them.
// - the mirrored core registers decode at indices 80h-84h, 8Ah and 8Bh of this bank.
// - index 93h reaches the address mask only in serial mode 1001 and the slave address otherwise.
// - port E pin 3 direction always reads one and ignores writes.
// - on the small variant the port D direction and port E direction bits 2-0 are absent and read zero.
`default_nettype none
package sfb_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [3:0] SER_MODE_MASKED = 4'h9;
  localparam logic [7:0] IDX_IND_WINDOW = 8'h80;
  localparam logic [7:0] IDX_T0_CTRL = 8'h81;
  localparam logic [7:0] IDX_PC_LOW = 8'h82;
  localparam logic [7:0] IDX_CORE_FLAGS = 8'h83;
  localparam logic [7:0] IDX_IND_POINTER = 8'h84;
  localparam logic [7:0] IDX_DIR_A = 8'h85;
  localparam logic [7:0] IDX_DIR_B = 8'h86;
  localparam logic [7:0] IDX_DIR_C = 8'h87;
  localparam logic [7:0] IDX_DIR_D = 8'h88;
  localparam logic [7:0] IDX_DIR_E = 8'h89;
  localparam logic [7:0] IDX_PC_UPPER = 8'h8a;
  localparam logic [7:0] IDX_IRQ_CTRL = 8'h8b;
  localparam logic [7:0] IDX_PIRQ_EN1 = 8'h8c;
  localparam logic [7:0] IDX_PIRQ_EN2 = 8'h8d;
  localparam logic [7:0] IDX_RST_CAUSE = 8'h8e;
  localparam logic [7:0] IDX_T1_GATE = 8'h8f;
  localparam logic [7:0] IDX_OSC_CTRL = 8'h90;
  localparam logic [7:0] IDX_OSC_TRIM = 8'h91;
  localparam logic [7:0] IDX_T2_PERIOD = 8'h92;
  localparam logic [7:0] IDX_SER_ADDR = 8'h93;
  localparam logic [7:0] IDX_SER_STAT = 8'h94;
  localparam logic [7:0] IDX_PULLUP_B = 8'h95;
  localparam logic [7:0] IDX_CHG_IRQ_B = 8'h96;
  localparam logic [7:0] IDX_USART_TX = 8'h98;
  localparam logic [7:0] IDX_BAUD_DIV = 8'h99;
  localparam logic [7:0] IDX_ALT_PIN = 8'h9c;
  localparam logic [7:0] IDX_VREF_CTRL = 8'h9d;
  localparam logic [7:0] IDX_SER_MODE = 8'ha0;
  localparam logic [7:0] IDX_VARIANT = 8'ha1;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_ONES = 8'hff;
  localparam logic [7:0] RST_CORE_FLAGS = 8'h18;
  localparam logic [7:0] RST_DIR_E = 8'h0f;
  localparam logic [7:0] RST_OSC_CTRL = 8'h20;
  localparam logic [7:0] RST_USART_TX = 8'h02;
  localparam logic [7:0] M_FULL = 8'hff;
  localparam logic [7:0] M_NONE = 8'h00;
  localparam logic [7:0] M_BIT0 = 8'h01;
  localparam logic [7:0] M_LOW2 = 8'h03;
  localparam logic [7:0] M_LOW3 = 8'h07;
  localparam logic [7:0] M_LOW4 = 8'h0f;
  localparam logic [7:0] M_LOW5 = 8'h1f;
  localparam logic [7:0] M_LOW6 = 8'h3f;
  localparam logic [7:0] M_DIR_E3 = 8'h08;
  localparam logic [7:0] M_FLAGS_W = 8'he7;
  localparam logic [7:0] M_T1G_W = 8'hfb;
  localparam logic [7:0] M_OSC_W = 8'h30;
  localparam logic [7:0] M_OSC_R = 8'h3c;
  localparam logic [7:0] M_SER_ST_W = 8'hc0;
  localparam logic [7:0] M_TX_W = 8'hf5;
  localparam logic [7:0] M_TX_R = 8'hf7;
  localparam logic [7:0] M_VREF_W = 8'h43;
  localparam logic [7:0] M_VREF_R = 8'hc3;

  typedef struct packed {
    logic [7:0] rst;
    logic [7:0] wm;
    logic [7:0] rm;
  } sfb_attr_t;

  // indirect window has no memory behind it here, so it reads zero
  function automatic sfb_attr_t reg_attr(input logic [7:0] idx);
    sfb_attr_t a;
    a = '{RST_ZERO, M_NONE, M_NONE};
    unique case (idx)
      IDX_T0_CTRL: a = '{RST_ONES, M_FULL, M_FULL};
      IDX_PC_LOW: a = '{RST_ZERO, M_FULL, M_FULL};
      IDX_CORE_FLAGS: a = '{RST_CORE_FLAGS, M_FLAGS_W, M_FULL};
      IDX_IND_POINTER: a = '{RST_ZERO, M_FULL, M_FULL};
      IDX_DIR_A, IDX_DIR_B, IDX_DIR_C, IDX_DIR_D: a = '{RST_ONES, M_FULL, M_FULL};
      IDX_DIR_E: a = '{RST_DIR_E, M_LOW3, M_LOW4};
      IDX_PC_UPPER: a = '{RST_ZERO, M_LOW5, M_LOW5};
      IDX_IRQ_CTRL, IDX_PIRQ_EN1: a = '{RST_ZERO, M_FULL, M_FULL};
      IDX_PIRQ_EN2: a = '{RST_ZERO, M_BIT0, M_BIT0};
      IDX_RST_CAUSE: a = '{RST_ZERO, M_LOW2, M_LOW2};
      IDX_T1_GATE: a = '{RST_ZERO, M_T1G_W, M_FULL};
      IDX_OSC_CTRL: a = '{RST_OSC_CTRL, M_OSC_W, M_OSC_R};
      IDX_OSC_TRIM: a = '{RST_ZERO, M_LOW6, M_LOW6};
      IDX_T2_PERIOD, IDX_PULLUP_B: a = '{RST_ONES, M_FULL, M_FULL};
      IDX_SER_ADDR, IDX_CHG_IRQ_B, IDX_BAUD_DIV: a = '{RST_ZERO, M_FULL, M_FULL};
      IDX_SER_STAT: a = '{RST_ZERO, M_SER_ST_W, M_FULL};
      IDX_USART_TX: a = '{RST_USART_TX, M_TX_W, M_TX_R};
      IDX_ALT_PIN: a = '{RST_ZERO, M_LOW2, M_LOW2};
      IDX_VREF_CTRL: a = '{RST_ZERO, M_VREF_W, M_VREF_R};
      IDX_SER_MODE: a = '{RST_ZERO, M_LOW4, M_LOW4};
      IDX_VARIANT: a = '{RST_ZERO, M_BIT0, M_BIT0};
      default: a = '{RST_ZERO, M_NONE, M_NONE};
    endcase
    return a;
  endfunction : reg_attr

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
    return (addr[11:10] == 2'h0) && (addr[9:2] >= IDX_IND_WINDOW) && (addr[9:2] <= IDX_VARIANT);
  endfunction : addr_mapped
endpackage : sfb_pkg
`default_nettype wire

/* sfb_axil_port.sv */
// Purpose: AXI4-Lite slave front end for the bank-1 register block
// Assumes: one write and one read outstanding at most
// Notes: byte lane 0 alone carries register data
`timescale 1ns/1ps
`default_nettype none
module sfb_axil_port (
  input  wire logic                        core_clk,
  input  wire logic                        resetn,
  input  wire logic [sfb_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [sfb_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  output logic                             wr_fire,
  output logic [7:0]                       wr_idx,
  output logic [7:0]                       wr_data,
  output logic                             wr_lane0,
  output logic                             rd_fire,
  output logic [7:0]                       rd_idx,
  input  wire logic [7:0]                  rd_byte
);
  logic       aw_have_r;
  logic       w_have_r;
  logic       aw_map_r;
  logic [7:0] aw_idx_r;
  logic [7:0] w_byte_r;
  logic       w_lane_r;

  assign wr_fire  = aw_have_r & w_have_r & ~s_axi_bvalid;
  assign wr_idx   = aw_idx_r;
  assign wr_data  = w_byte_r;
  assign wr_lane0 = w_lane_r & aw_map_r;
  assign rd_fire  = s_axi_arvalid & s_axi_arready;
  assign rd_idx   = s_axi_araddr[9:2];

  // ready drops once a half is held, so a second address cannot overwrite it
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      aw_map_r      <= 1'b0;
      aw_idx_r      <= 8'h00;
      w_byte_r      <= 8'h00;
      w_lane_r      <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= sfb_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r     <= 1'b1;
        aw_idx_r      <= s_axi_awaddr[9:2];
        aw_map_r      <= sfb_pkg::addr_mapped(s_axi_awaddr);
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r     <= 1'b1;
        w_byte_r     <= s_axi_wdata[7:0];
        w_lane_r     <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= aw_map_r ? sfb_pkg::RESP_OKAY : sfb_pkg::RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= sfb_pkg::RESP_OKAY;
    end else begin
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= sfb_pkg::addr_mapped(s_axi_araddr) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        s_axi_rresp   <= sfb_pkg::addr_mapped(s_axi_araddr) ? sfb_pkg::RESP_OKAY : sfb_pkg::RESP_DECERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule : sfb_axil_port
`default_nettype wire

/* sfb_bank1.sv */
// Purpose: bank-1 special register decode, storage and read-back
// Assumes: core logic on core_clk drives pc_step; no other bank here
// Notes: peripheral status bits hold their reset values in this block
`timescale 1ns/1ps
`default_nettype none
module sfb_bank1 (
  input  wire logic                        core_clk,
  input  wire logic                        resetn,
  input  wire logic [sfb_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [sfb_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        pc_step,
  output logic [12:0]                      pc_value,
  output logic [7:0]                       ind_pointer,
  output logic [7:0]                       dir_a,
  output logic [7:0]                       dir_b,
  output logic [7:0]                       dir_c,
  output logic [7:0]                       dir_d,
  output logic [7:0]                       dir_e,
  output logic [7:0]                       ser_address,
  output logic [7:0]                       ser_addr_mask
);
  localparam logic [4:0] SLOT_PC_UPPER = sfb_pkg::IDX_PC_UPPER[4:0];
  localparam logic [4:0] SLOT_SER_ADDR = sfb_pkg::IDX_SER_ADDR[4:0];
  localparam logic [4:0] SLOT_DIR_A    = sfb_pkg::IDX_DIR_A[4:0];
  localparam logic [4:0] SLOT_DIR_B    = sfb_pkg::IDX_DIR_B[4:0];
  localparam logic [4:0] SLOT_DIR_C    = sfb_pkg::IDX_DIR_C[4:0];
  localparam logic [4:0] SLOT_DIR_D    = sfb_pkg::IDX_DIR_D[4:0];
  localparam logic [4:0] SLOT_DIR_E    = sfb_pkg::IDX_DIR_E[4:0];
  localparam logic [4:0] SLOT_IND_PTR  = sfb_pkg::IDX_IND_POINTER[4:0];

  logic [7:0]  regs_r [0:31];
  logic [12:0] pc_r;
  logic [7:0]  ser_mask_r;
  logic [3:0]  ser_mode_r;
  logic        small_r;
  logic        wr_fire;
  logic [7:0]  wr_idx;
  logic [7:0]  wr_data;
  logic        wr_lane0;
  logic        rd_fire;
  logic [7:0]  rd_idx;
  logic [7:0]  rd_byte;
  logic        wr_en;
  logic        wr_in_bank;
  logic        rd_in_bank;
  logic        masked_mode;
  logic [7:0]  wr_wm;
  logic [7:0]  mask_wm;
  logic [7:0]  bank_raw;
  sfb_pkg::sfb_attr_t wr_attr;
  sfb_pkg::sfb_attr_t rd_attr;

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] data, input logic [7:0] wm);
    return (old & ~wm) | (data & wm);
  endfunction : merge

  function automatic logic is_mirror(input logic [7:0] idx);
    return (idx >= sfb_pkg::IDX_IND_WINDOW && idx <= sfb_pkg::IDX_IND_POINTER) ||
           idx == sfb_pkg::IDX_PC_UPPER || idx == sfb_pkg::IDX_IRQ_CTRL;
  endfunction : is_mirror

  // struct member taken here, since a select straight on a call result is not portable
  function automatic logic [7:0] reset_byte(input logic [7:0] idx);
    sfb_pkg::sfb_attr_t a;
    a = sfb_pkg::reg_attr(idx);
    return a.rst;
  endfunction : reset_byte

  sfb_axil_port u_port (
    .core_clk      (core_clk),
    .resetn        (resetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_fire       (wr_fire),
    .wr_idx        (wr_idx),
    .wr_data       (wr_data),
    .wr_lane0      (wr_lane0),
    .rd_fire       (rd_fire),
    .rd_idx        (rd_idx),
    .rd_byte       (rd_byte)
  );

  assign wr_en       = wr_fire & wr_lane0;
  assign wr_in_bank  = wr_idx[7:5] == 3'h4;
  assign rd_in_bank  = rd_idx[7:5] == 3'h4;
  assign wr_attr     = sfb_pkg::reg_attr(wr_idx);
  assign rd_attr     = sfb_pkg::reg_attr(rd_idx);
  assign masked_mode = ser_mode_r == sfb_pkg::SER_MODE_MASKED;

  // write masks after variant and serial-mode steering
  always_comb begin
    wr_wm   = wr_attr.wm;
    mask_wm = sfb_pkg::M_NONE;
    if (!wr_in_bank) begin
      wr_wm = sfb_pkg::M_NONE;
    end
    if (wr_idx == sfb_pkg::IDX_PC_LOW) begin
      wr_wm = sfb_pkg::M_NONE;
    end
    if (wr_idx == sfb_pkg::IDX_SER_ADDR && masked_mode) begin
      mask_wm = sfb_pkg::M_FULL;
      wr_wm   = sfb_pkg::M_NONE;
    end
    if (small_r && (wr_idx == sfb_pkg::IDX_DIR_D || wr_idx == sfb_pkg::IDX_DIR_E)) begin
      wr_wm = sfb_pkg::M_NONE;
    end
  end

  // shaded slots have a zero write mask and so keep their zero
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      for (int i = 0; i < 32; i++) begin
        regs_r[i] <= reset_byte(sfb_pkg::IDX_IND_WINDOW + 8'(i));
      end
    end else if (wr_en) begin
      regs_r[wr_idx[4:0]] <= merge(regs_r[wr_idx[4:0]], wr_data, wr_wm);
    end
  end

  // upper bits load only through the latch, never straight from the bus; pc_step carries into them
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pc_r <= 13'h0000;
    end else if (wr_en && wr_idx == sfb_pkg::IDX_PC_LOW) begin
      pc_r <= {regs_r[SLOT_PC_UPPER][4:0], wr_data};
    end else if (pc_step) begin
      pc_r <= pc_r + 13'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ser_mask_r <= sfb_pkg::RST_ONES;
    end else if (wr_en) begin
      ser_mask_r <= merge(ser_mask_r, wr_data, mask_wm);
    end
  end

  // mode and variant normally come from elsewhere; here software sets them
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ser_mode_r <= sfb_pkg::RST_ZERO[3:0];
      small_r    <= sfb_pkg::RST_ZERO[0];
    end else if (wr_en && wr_idx == sfb_pkg::IDX_SER_MODE) begin
      ser_mode_r <= wr_data[3:0];
    end else if (wr_en && wr_idx == sfb_pkg::IDX_VARIANT) begin
      small_r <= wr_data[0];
    end
  end

  // read mux; the read mask zeroes every unimplemented bit
  always_comb begin
    bank_raw = rd_in_bank ? regs_r[rd_idx[4:0]] : 8'h00;
    rd_byte  = bank_raw & rd_attr.rm;
    unique case (rd_idx)
      sfb_pkg::IDX_PC_LOW: begin
        rd_byte = pc_r[7:0];
      end
      sfb_pkg::IDX_SER_ADDR: begin
        rd_byte = masked_mode ? ser_mask_r : regs_r[SLOT_SER_ADDR];
      end
      sfb_pkg::IDX_DIR_D: begin
        rd_byte = small_r ? 8'h00 : regs_r[SLOT_DIR_D];
      end
      sfb_pkg::IDX_DIR_E: begin
        rd_byte = sfb_pkg::M_DIR_E3 | (small_r ? 8'h00 : (regs_r[SLOT_DIR_E] & sfb_pkg::M_LOW3));
      end
      sfb_pkg::IDX_SER_MODE: begin
        rd_byte = {4'h0, ser_mode_r};
      end
      sfb_pkg::IDX_VARIANT: begin
        rd_byte = {7'h00, small_r};
      end
      default: begin
        rd_byte = bank_raw & rd_attr.rm;
      end
    endcase
  end

  // outputs lag the registers by one cycle so every port is a flop
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pc_value      <= 13'h0000;
      ind_pointer   <= sfb_pkg::RST_ZERO;
      dir_a         <= sfb_pkg::RST_ONES;
      dir_b         <= sfb_pkg::RST_ONES;
      dir_c         <= sfb_pkg::RST_ONES;
      dir_d         <= sfb_pkg::RST_ONES;
      dir_e         <= sfb_pkg::RST_DIR_E;
      ser_address   <= sfb_pkg::RST_ZERO;
      ser_addr_mask <= sfb_pkg::RST_ONES;
    end else begin
      pc_value      <= pc_r;
      ind_pointer   <= regs_r[SLOT_IND_PTR];
      dir_a         <= regs_r[SLOT_DIR_A];
      dir_b         <= regs_r[SLOT_DIR_B];
      dir_c         <= regs_r[SLOT_DIR_C];
      dir_d         <= small_r ? 8'h00 : regs_r[SLOT_DIR_D];
      dir_e         <= sfb_pkg::M_DIR_E3 | (small_r ? 8'h00 : (regs_r[SLOT_DIR_E] & sfb_pkg::M_LOW3));
      ser_address   <= regs_r[SLOT_SER_ADDR];
      ser_addr_mask <= ser_mask_r;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  unimpl_read_zero_a: assert property (
    rd_fire && rd_attr.rm == 8'h00 && rd_idx != sfb_pkg::IDX_DIR_E
    |=> s_axi_rdata == 32'h0000_0000)
    else $error("unimplemented slot read nonzero");

  unimpl_write_ignored_a: assert property (
    wr_en && wr_idx == 8'h97 |=> $stable(regs_r[5'h17]) && regs_r[5'h17] == 8'h00)
    else $error("shaded slot took a write");

  pc_upper_load_a: assert property (
    wr_en && wr_idx == sfb_pkg::IDX_PC_LOW
    |=> pc_r == {$past(regs_r[SLOT_PC_UPPER][4:0]), $past(wr_data)} ##1 pc_value == $past(pc_r))
    else $error("pc load did not take the upper latch");

  pc_upper_hidden_a: assert property (
    rd_fire && rd_idx == sfb_pkg::IDX_PC_LOW |=> s_axi_rdata == {24'h00_0000, $past(pc_r[7:0])})
    else $error("pc read showed more than the low byte");

  mirror_decode_a: assert property (
    rd_fire && is_mirror(rd_idx) && s_axi_araddr[11:10] == 2'h0
    |=> s_axi_rresp == sfb_pkg::RESP_OKAY && s_axi_rdata[31:8] == 24'h00_0000)
    else $error("mirrored register not decoded");

  ser_shared_slot_a: assert property (
    rd_fire && rd_idx == sfb_pkg::IDX_SER_ADDR
    |=> s_axi_rdata[7:0] == ($past(masked_mode) ? $past(ser_mask_r) : $past(regs_r[SLOT_SER_ADDR])))
    else $error("shared serial slot chose the wrong register");

  dir_e3_fixed_a: assert property (
    rd_fire && rd_idx == sfb_pkg::IDX_DIR_E && s_axi_araddr[11:10] == 2'h0 |=> s_axi_rdata[3] && dir_e[3])
    else $error("port E pin 3 direction not one");

  small_absent_a: assert property (
    rd_fire && small_r && (rd_idx == sfb_pkg::IDX_DIR_D || rd_idx == sfb_pkg::IDX_DIR_E) && s_axi_araddr[11:10] == 2'h0
    |=> s_axi_rdata[7:0] == (($past(rd_idx) == sfb_pkg::IDX_DIR_E) ? sfb_pkg::M_DIR_E3 : 8'h00))
    else $error("absent direction bits read nonzero");

  reset_values_a: assert property (disable iff (1'b0)
    !resetn |=> pc_r == 13'h0000 && ser_mask_r == 8'hff && regs_r[SLOT_DIR_A] == 8'hff
    && regs_r[SLOT_DIR_E] == 8'h0f && regs_r[SLOT_PC_UPPER] == 8'h00)
    else $error("register missed its reset value");
endmodule : sfb_bank1
`default_nettype wire

/* sfb_bank1_bench.sv */
// Purpose: self-checking bench for the bank-1 register block
// Assumes: byte address = index * 4, data in byte lane 0
// Notes: bench acts as the AXI4-Lite master
`timescale 1ns/1ps
`default_nettype none
module sfb_bank1_bench;
  logic [sfb_pkg::ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]                s_axi_wdata, s_axi_rdata, q;
  logic [3:0]                 s_axi_wstrb;
  logic [1:0]                 s_axi_bresp, s_axi_rresp, r;
  logic                       core_clk, resetn, pc_step, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic                       s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                       s_axi_rvalid, s_axi_rready;
  logic [12:0]                pc_value;
  logic [7:0]                 ind_pointer, dir_a, dir_b, dir_c, dir_d, dir_e, ser_address, ser_addr_mask;
  int                         errors, samples_checked, cyc;

  sfb_bank1 i_sfb_bank1 (.core_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pc_step,
    .pc_value, .ind_pointer, .dir_a, .dir_b, .dir_c, .dir_d, .dir_e, .ser_address, .ser_addr_mask);

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // a lost handshake would hang the run, so cap it well above the few hundred cycles used
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 8000) begin
      errors++;
      results();
    end
  end

  task automatic results;
    if (errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] h = 2'h0);
    @(posedge core_clk);
    s_axi_awaddr  <= {h, i, 2'h0};
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] i, input logic [1:0] h = 2'h0);
    @(posedge core_clk);
    s_axi_araddr  <= {h, i, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    q = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rc(input logic [7:0] i, input logic [7:0] e);
    rd(i);
    chk($sformatf("reg %h", i), q, {24'h0, e});
    chk("rresp", {30'h0, r}, 32'h0);
  endtask : rc

  task automatic t_reset;
    logic [15:0] t [14] = '{16'h81ff, 16'h8200, 16'h8318, 16'h8400, 16'h85ff, 16'h88ff, 16'h890f,
      16'h8a00, 16'h8b00, 16'h9020, 16'h92ff, 16'h9300, 16'h95ff, 16'h9802};
    foreach (t[k]) rc(t[k][15:8], t[k][7:0]);
    chk("dir_a", {24'h0, dir_a}, 32'hff);
    chk("dir_b", {24'h0, dir_b}, 32'hff);
    chk("dir_c", {24'h0, dir_c}, 32'hff);
    chk("mask", {24'h0, ser_addr_mask}, 32'hff);
  endtask : t_reset

  task automatic t_masks;
    logic [15:0] t [14] = '{16'h8000, 16'h8d01, 16'h8e03, 16'h8ffb, 16'h9030, 16'h913f, 16'h9700,
      16'h98f7, 16'h9a00, 16'h9b00, 16'h9c03, 16'h9d43, 16'h9e00, 16'h9f00};
    foreach (t[k]) begin
      wr(t[k][15:8], 8'hff);
      chk("bresp", {30'h0, r}, 32'h0);
      rc(t[k][15:8], t[k][7:0]);
    end
    wr(8'ha2, 8'hff);
    chk("bresp", {30'h0, r}, 32'h3);
    rd(8'h81, 2'h1);
    chk("rdata", q, 32'h0);
    chk("rresp", {30'h0, r}, 32'h3);
  endtask : t_masks

  task automatic t_pc;
    wr(8'h8a, 8'hff);
    rc(8'h8a, 8'h1f);
    chk("pc", {19'h0, pc_value}, 32'h0);
    wr(8'h82, 8'hfe);
    repeat (2) @(posedge core_clk);
    chk("pc", {19'h0, pc_value}, 32'h1ffe);
    pc_step <= 1'b1;
    repeat (2) @(posedge core_clk);
    pc_step <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("pc", {19'h0, pc_value}, 32'h0);
    rc(8'h82, 8'h00);
  endtask : t_pc

  task automatic t_mirror;
    wr(8'h84, 8'ha5);
    rc(8'h84, 8'ha5);
    chk("pointer", {24'h0, ind_pointer}, 32'ha5);
    wr(8'h8b, 8'h5a);
    rc(8'h8b, 8'h5a);
    wr(8'h83, 8'h00);
    rc(8'h83, 8'h18);
  endtask : t_mirror

  task automatic t_mode;
    wr(8'h93, 8'h3c);
    wr(8'ha0, 8'h09);
    rc(8'h93, 8'hff);
    wr(8'h93, 8'h0f);
    rc(8'h93, 8'h0f);
    chk("addr", {24'h0, ser_address}, 32'h3c);
    wr(8'ha0, 8'h08);
    rc(8'h93, 8'h3c);
    // mode 1 differs from 9 in bit 3 alone, so a partial compare shows
    wr(8'ha0, 8'h01);
    rc(8'h93, 8'h3c);
  endtask : t_mode

  task automatic t_porte;
    wr(8'h89, 8'h00);
    rc(8'h89, 8'h08);
    wr(8'h89, 8'hff);
    rc(8'h89, 8'h0f);
    wr(8'ha1, 8'h01);
    wr(8'h88, 8'h12);
    rc(8'h88, 8'h00);
    rc(8'h89, 8'h08);
    chk("dir_d", {24'h0, dir_d}, 32'h0);
    chk("dir_e", {24'h0, dir_e}, 32'h08);
    wr(8'ha1, 8'h00);
    rc(8'h88, 8'hff);
    // lane 0 off: the write is dropped but still answered
    s_axi_wstrb <= 4'he;
    wr(8'h95, 8'h00);
    chk("bresp", {30'h0, r}, 32'h0);
    rc(8'h95, 8'hff);
    s_axi_wstrb <= 4'hf;
  endtask : t_porte

  initial begin
    {resetn, pc_step, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hf;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset();
    t_masks();
    t_pc();
    t_mirror();
    t_mode();
    t_porte();
    results();
  end
endmodule : sfb_bank1_bench
`default_nettype wire
